// ===== rtl/evpc_pkg.sv
// How it works
// - Drive pilot with 1 kHz bipolar PWM.
// - Duty cycle advertises the maximum available current.
// - From 6 to 51 A, duty equals amps/0.6.
// - From 51 to 80 A, duty is amps/2.5+64.
// - Hardware timer makes PWM; rating is a constant.
// - Optional derating input lowers the advertised duty.
// - Complete self tests before entering idle.
// - Idle holds steady positive DC, no modulation.
// - Seeing 9 V enters ready and starts PWM.
// - Connected sequence energises the charging relays.
// - Vehicle drops to 6 V; classify as charging.
// - 3 V means charging with ventilation required.
// - Return to 12 V ends session, back idle.
// - Faults de-energise relays: 0 V, diode, connection.
// - Sample the divided pilot with ADC once per period, except in error states.
package evpc_pkg;

  localparam int CLK_HZ       = 200_000_000;
  localparam int PWM_HZ       = 1000;
  localparam int PWM_PERIOD   = CLK_HZ / PWM_HZ;
  localparam int PWM_CNT_W    = 18;
  localparam int SELFTEST_US  = 10;
  localparam int SELFTEST_CYC = SELFTEST_US * (CLK_HZ / 1_000_000);
  localparam int ST_CNT_W     = 12;

  localparam int AMP_W = 7;
  localparam logic [AMP_W-1:0] AMP_MIN    = 7'h06;
  localparam logic [AMP_W-1:0] AMP_KNEE   = 7'h33;
  localparam logic [AMP_W-1:0] AMP_MAX    = 7'h50;
  localparam int               RATED_AMPS = 30;

  localparam int PM_W = 10;
  localparam logic [13:0] PM_LOW_MUL  = 14'h0032;
  localparam logic [13:0] PM_LOW_DIV  = 14'h0003;
  localparam logic [13:0] PM_HIGH_MUL = 14'h0004;
  localparam logic [13:0] PM_HIGH_OFS = 14'h0280;
  localparam logic [27:0] PM_FULL     = 28'h00003E8;

  // ADC full scale stands for 12 V; thresholds sit midway between levels.
  localparam int ADC_W = 10;
  localparam logic [ADC_W-1:0] THR_10V5 = 10'h37F;
  localparam logic [ADC_W-1:0] THR_7V5  = 10'h27F;
  localparam logic [ADC_W-1:0] THR_4V5  = 10'h17F;
  localparam logic [ADC_W-1:0] THR_1V5  = 10'h07F;

  localparam int             DEB_W   = 3;
  localparam logic [DEB_W-1:0] DEB_LAST = 3'h3;

  typedef enum logic [6:0] {
    ST_SELFTEST = 7'h01,
    ST_IDLE     = 7'h02,
    ST_READY    = 7'h04,
    ST_CHARGE   = 7'h08,
    ST_VENT     = 7'h10,
    ST_ERR_E    = 7'h20,
    ST_ERR_F    = 7'h40
  } evpc_state_e;

  typedef enum logic [4:0] {
    LV_12 = 5'h01,
    LV_9  = 5'h02,
    LV_6  = 5'h04,
    LV_3  = 5'h08,
    LV_0  = 5'h10
  } evpc_lvl_e;

  typedef struct packed {
    evpc_state_e state;
    evpc_lvl_e   level;
    logic        relay;
    logic        error;
  } evpc_status_s;

  function automatic evpc_lvl_e evpc_classify(input logic [ADC_W-1:0] code);
    if (code >= THR_10V5) return LV_12;
    else if (code >= THR_7V5) return LV_9;
    else if (code >= THR_4V5) return LV_6;
    else if (code >= THR_1V5) return LV_3;
    else return LV_0;
  endfunction

  function automatic logic [PM_W-1:0] evpc_duty_pm(input logic [AMP_W-1:0] amps);
    logic [AMP_W-1:0] a;
    logic [13:0]      t;
    a = (amps < AMP_MIN) ? AMP_MIN : ((amps > AMP_MAX) ? AMP_MAX : amps);
    if (a <= AMP_KNEE) begin
      t = (14'(a) * PM_LOW_MUL) / PM_LOW_DIV;
    end else begin
      t = 14'(a) * PM_HIGH_MUL + PM_HIGH_OFS;
    end
    return t[PM_W-1:0];
  endfunction

endpackage

// ===== rtl/evpc_pwm_timer.sv
`timescale 1ns/1ps
`default_nettype none
module evpc_pwm_timer
  import evpc_pkg::*;
#(
  parameter int PERIOD_CYC = PWM_PERIOD
) (
  input  wire logic                 mclk,       // System clock.
  input  wire logic                 rstn,       // Synchronous reset, active low.
  input  wire logic                 run,        // Modulate; otherwise steady high.
  input  wire logic [PWM_CNT_W-1:0] high_cyc,   // High-phase length in cycles.
  output logic                      phase_hi,   // Positive phase of the pilot.
  output logic                      sample_stb  // Pulse in middle of positive phase.
);

  localparam logic [PWM_CNT_W-1:0] LAST = PWM_CNT_W'(PERIOD_CYC - 1);

  logic [PWM_CNT_W-1:0] cnt_r;
  logic [PWM_CNT_W-1:0] mid;

  // When idle the sample point is mid-period so the DC level is still watched.
  assign mid = run ? (high_cyc >> 1) : PWM_CNT_W'(PERIOD_CYC / 2);

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      cnt_r <= '0;
    end else if (cnt_r == LAST) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      phase_hi   <= 1'b1;
      sample_stb <= 1'b0;
    end else begin
      phase_hi   <= run ? (cnt_r < high_cyc) : 1'b1;
      sample_stb <= (cnt_r == mid);
    end
  end

  chk_period_wrap: assert property (@(posedge mclk) disable iff (!rstn)
    cnt_r == LAST |=> cnt_r == '0)
    else $error("PWM counter did not wrap at period end");

endmodule
`default_nettype wire

// ===== rtl/evpc_lvl_filter.sv
`timescale 1ns/1ps
`default_nettype none
module evpc_lvl_filter
  import evpc_pkg::*;
(
  input  wire logic             mclk,     // System clock.
  input  wire logic             rstn,     // Synchronous reset, active low.
  input  wire logic [ADC_W-1:0] adc_code, // Conversion result.
  input  wire logic             adc_done, // Result valid pulse.
  output evpc_lvl_e             lvl,      // Debounced pilot level.
  output logic                  lvl_vld   // A debounced level exists.
);

  evpc_lvl_e        cand_r;
  evpc_lvl_e        cls;
  logic [DEB_W-1:0] cnt_r;

  assign cls = evpc_classify(adc_code);

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      cand_r  <= LV_12;
      cnt_r   <= '0;
      lvl     <= LV_12;
      lvl_vld <= 1'b0;
    end else if (adc_done) begin
      if (cls != cand_r) begin
        cand_r <= cls;
        cnt_r  <= '0;
      end else if (cnt_r != DEB_LAST) begin
        cnt_r <= cnt_r + 1'b1;
      end else begin
        lvl     <= cand_r;
        lvl_vld <= 1'b1;
      end
    end
  end

  chk_debounce_hold: assert property (@(posedge mclk) disable iff (!rstn)
    $changed(lvl) |-> $past(cnt_r) == DEB_LAST && $past(adc_done))
    else $error("Level changed without a full debounce run");

endmodule
`default_nettype wire

// ===== rtl/evpc_pilot_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module evpc_pilot_ctrl
  import evpc_pkg::*;
#(
  parameter int PERIOD_CYC = PWM_PERIOD,
  parameter int RATED      = RATED_AMPS
) (
  input  wire logic             mclk,          // System clock, 200 MHz.
  input  wire logic             rstn,          // Synchronous reset, active low.
  input  wire logic [ADC_W-1:0] adc_code,      // Divided pilot conversion result.
  input  wire logic             adc_done,      // Conversion finished pulse.
  input  wire logic             selftest_pass, // Self tests passed.
  input  wire logic             fault_in,      // Improper connection or diode fault.
  input  wire logic             fault_clr,     // Leave an error state.
  input  wire logic             derate_en,     // Operator derating active.
  input  wire logic [AMP_W-1:0] derate_amps,   // Operator current limit.
  output logic                  adc_start,     // Start one conversion.
  output logic                  pilot_pos,     // Drive pilot to +12 V.
  output logic                  pilot_neg,     // Drive pilot to -12 V.
  output logic                  relay_on,      // Energise charging relays.
  output logic                  evt_pulse,     // One cycle on each transition.
  output evpc_status_s          status         // State, level, relay and error.
);

  localparam logic [AMP_W-1:0] RATED_A = AMP_W'(RATED);

  evpc_state_e          state_r;
  evpc_state_e          state_nxt;
  evpc_lvl_e            lvl;
  logic                 lvl_vld;
  logic                 phase_hi;
  logic                 sample_stb;
  logic                 run;
  logic [AMP_W-1:0]     eff_amps;
  logic [PM_W-1:0]      duty_pm;
  logic [PWM_CNT_W-1:0] high_cyc_r;
  logic [ST_CNT_W-1:0]  st_cnt_r;
  logic                 st_done;
  logic                 is_err;
  logic                 is_live;
  logic                 filt_rstn;

  // Charging-related states, in which the pilot is modulated.
  assign is_live = (state_r == ST_READY) || (state_r == ST_CHARGE)
                   || (state_r == ST_VENT);
  assign is_err  = (state_r == ST_ERR_E) || (state_r == ST_ERR_F);
  assign run     = is_live;

  // The level filter restarts with every self test, so a level left over from
  // the session before an error cannot throw the new idle state out at once.
  assign filt_rstn = rstn && (state_r != ST_SELFTEST);

  // The operator may only lower the limit, never raise it above the rating.
  assign eff_amps = (derate_en && (derate_amps < RATED_A))
                    ? derate_amps : RATED_A;
  assign duty_pm  = evpc_duty_pm(eff_amps);

  // Registered so the wide multiply and divide stay off the timer path.
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      high_cyc_r <= '0;
    end else begin
      high_cyc_r <= PWM_CNT_W'((28'(PERIOD_CYC) * 28'(duty_pm)) / PM_FULL);
    end
  end

  evpc_pwm_timer #(
    .PERIOD_CYC (PERIOD_CYC)
  ) u_timer (
    .mclk       (mclk),
    .rstn       (rstn),
    .run        (run),
    .high_cyc   (high_cyc_r),
    .phase_hi   (phase_hi),
    .sample_stb (sample_stb)
  );

  evpc_lvl_filter u_filter (
    .mclk     (mclk),
    .rstn     (filt_rstn),
    .adc_code (adc_code),
    .adc_done (adc_done),
    .lvl      (lvl),
    .lvl_vld  (lvl_vld)
  );

  // Self-test timer. It rests at zero outside self test, so every entry,
  // including the one after an error clear, runs the full span.
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      st_cnt_r <= '0;
    end else if (state_r != ST_SELFTEST) begin
      st_cnt_r <= '0;
    end else if (!st_done) begin
      st_cnt_r <= st_cnt_r + 1'b1;
    end
  end

  assign st_done = (st_cnt_r == ST_CNT_W'(SELFTEST_CYC - 1));

  // Errors are latched: only an explicit clear leaves them, and that clear
  // always runs the self test again before the pilot is offered to a vehicle.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_SELFTEST: begin
        if (st_done) begin
          state_nxt = selftest_pass ? ST_IDLE : ST_ERR_F;
        end
      end
      ST_IDLE: begin
        if (fault_in) begin
          state_nxt = ST_ERR_F;
        end else if (lvl_vld && lvl == LV_0) begin
          state_nxt = ST_ERR_E;
        end else if (lvl_vld && lvl != LV_12) begin
          state_nxt = ST_READY;
        end
      end
      ST_READY, ST_CHARGE, ST_VENT: begin
        if (fault_in) begin
          state_nxt = ST_ERR_F;
        end else if (lvl_vld) begin
          case (lvl)
            LV_12:   state_nxt = ST_IDLE;
            LV_9:    state_nxt = ST_READY;
            LV_6:    state_nxt = ST_CHARGE;
            LV_3:    state_nxt = ST_VENT;
            LV_0:    state_nxt = ST_ERR_E;
            default: state_nxt = ST_ERR_F;
          endcase
        end
      end
      ST_ERR_E, ST_ERR_F: begin
        if (fault_clr) begin
          state_nxt = ST_SELFTEST;
        end
      end
      default: state_nxt = ST_ERR_F;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      state_r <= ST_SELFTEST;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Pilot drive: DC high before a vehicle, PWM while connected,
  // 0 V for a shorted pilot, steady negative for an unknown fault.
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      pilot_pos <= 1'b0;
      pilot_neg <= 1'b0;
    end else begin
      case (state_r)
        ST_SELFTEST, ST_IDLE: begin
          pilot_pos <= 1'b1;
          pilot_neg <= 1'b0;
        end
        ST_READY, ST_CHARGE, ST_VENT: begin
          pilot_pos <= phase_hi;
          pilot_neg <= !phase_hi;
        end
        ST_ERR_E: begin
          pilot_pos <= 1'b0;
          pilot_neg <= 1'b0;
        end
        default: begin
          pilot_pos <= 1'b0;
          pilot_neg <= 1'b1;
        end
      endcase
    end
  end

  // The relays close only once the vehicle asks for power, so that any
  // other state, including a stuck controller after reset, leaves them open.
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      relay_on <= 1'b0;
    end else begin
      relay_on <= (state_r == ST_CHARGE) || (state_r == ST_VENT);
    end
  end

  // No conversions are asked for in an error state, because no level can
  // lead out of one and a shorted pilot is not worth sampling.
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      adc_start <= 1'b0;
    end else begin
      adc_start <= sample_stb && !is_err;
    end
  end

  // Status follows the next state, so that it, the state register and the
  // event pulse all change on one edge.
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      evt_pulse <= 1'b0;
      status    <= '{state: ST_SELFTEST, level: LV_12, relay: 1'b0, error: 1'b0};
    end else begin
      evt_pulse    <= (state_nxt != state_r);
      status.state <= state_nxt;
      status.level <= lvl;
      status.relay <= (state_nxt == ST_CHARGE) || (state_nxt == ST_VENT);
      status.error <= (state_nxt == ST_ERR_E) || (state_nxt == ST_ERR_F);
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  chk_boot_selftest: assert property ($rose(rstn) |-> state_r == ST_SELFTEST)
    else $error("State after reset is not self test");

  chk_relay_safe: assert property (relay_on |-> $past(state_r) == ST_CHARGE
    || $past(state_r) == ST_VENT)
    else $error("Relay energised outside charging");

  chk_err_relay: assert property (is_err |=> !relay_on)
    else $error("Relay energised in an error state");

  chk_idle_dc: assert property (state_r == ST_IDLE && $past(state_r) == ST_IDLE
    |-> pilot_pos && !pilot_neg)
    else $error("Idle pilot is not steady positive");

  chk_plug_ready: assert property (state_r == ST_IDLE && !fault_in && lvl_vld
    && lvl == LV_9 |=> state_r == ST_READY)
    else $error("9 V in idle did not enter ready");

  chk_unplug_idle: assert property (is_live && !fault_in && lvl_vld
    && lvl == LV_12 |=> state_r == ST_IDLE)
    else $error("Unplug did not return to idle");

  chk_charge_vent: assert property (is_live && !fault_in && lvl_vld
    && (lvl == LV_6 || lvl == LV_3)
    |=> state_r == ($past(lvl) == LV_6 ? ST_CHARGE : ST_VENT) ##1 relay_on)
    else $error("Charging level not classified or relay not closed");

  chk_evt_flag: assert property ($changed(status.state) |-> evt_pulse
    && status.state == state_r)
    else $error("State change without event pulse");

  chk_duty_low: assert property (eff_amps == 7'h1E |-> duty_pm == 10'h1F4)
    else $error("30 A does not give 50 percent duty");

  chk_duty_high: assert property (eff_amps == 7'h50 |-> duty_pm == 10'h3C0)
    else $error("80 A does not give 96 percent duty");

  chk_derate: assert property (derate_en && derate_amps < RATED_A
    |-> eff_amps == derate_amps)
    else $error("Derating limit not applied");

  chk_pwm_neg: assert property (is_live && $past(is_live) && !phase_hi
    |=> pilot_neg && !pilot_pos)
    else $error("Negative phase not driven while connected");

  // The conversion start lags the counter by two registers, so the sampling
  // check needs the pilot to have been live for those two cycles.
  chk_sample_pos: assert property (adc_start && $past(is_live)
    && $past(is_live, 2) |-> pilot_pos)
    else $error("Conversion started outside the positive phase");

  chk_adc_quiet: assert property (is_err |=> !adc_start)
    else $error("Conversion started in an error state");

  chk_st_fail: assert property (state_r == ST_SELFTEST && st_done && !selftest_pass
    |=> state_r == ST_ERR_F)
    else $error("Failed self test did not enter error F");

  chk_fault_f: assert property ((state_r == ST_IDLE || is_live) && fault_in
    |=> state_r == ST_ERR_F)
    else $error("Fault input did not enter error F");

  chk_short_pilot: assert property (state_r == ST_ERR_E
    && $past(state_r) == ST_ERR_E |-> !pilot_pos && !pilot_neg)
    else $error("Pilot not at 0 V in error E");

  chk_err_hold: assert property (is_err && !fault_clr |=> state_r == $past(state_r))
    else $error("Error state left without a clear");

  chk_err_flag: assert property (is_err |-> status.error && status.state == state_r)
    else $error("Error state not flagged in status");

  chk_selftest_dc: assert property (state_r == ST_SELFTEST && $past(rstn)
    && $past(state_r) == ST_SELFTEST |-> pilot_pos && !pilot_neg)
    else $error("Self test pilot is not steady positive");

  chk_ready_open: assert property (state_r == ST_READY |=> !relay_on)
    else $error("Relay energised while only ready");

  chk_evt_quiet: assert property (state_nxt == state_r |=> !evt_pulse)
    else $error("Event pulse without a state change");

  // Main scenarios: plug-in, charging, ventilation, short and fault.
  cov_plug: cover property (state_r == ST_IDLE ##1 state_r == ST_READY);
  cov_charge: cover property (state_r == ST_READY ##1 state_r == ST_CHARGE);
  cov_vent: cover property (state_r == ST_CHARGE ##1 state_r == ST_VENT);
  cov_short: cover property (is_live ##1 state_r == ST_ERR_E);
  cov_fault: cover property (state_r == ST_IDLE ##1 state_r == ST_ERR_F);

endmodule
`default_nettype wire

// ===== testbench/evpc_vehicle.sv
`timescale 1ns/1ps
`default_nettype none
module evpc_vehicle
  import evpc_pkg::*;
(
  input  wire logic             mclk,      // System clock.
  input  wire logic             adc_start, // Conversion request.
  input  wire logic             pilot_pos, // Pilot driven to +12 V.
  input  wire evpc_lvl_e        load,      // Load chosen by the bench.
  input  wire logic             slow,      // Answer late instead of promptly.
  output logic [ADC_W-1:0]      adc_code,  // Conversion result.
  output logic                  adc_done   // Result valid pulse.
);
  logic [ADC_W-1:0] held;
  int               wait_n;

  function automatic logic [ADC_W-1:0] code_of(input evpc_lvl_e l);
    case (l)
      LV_12:   return 10'h3FF;
      LV_9:    return 10'h2FF;
      LV_6:    return 10'h1FF;
      LV_3:    return 10'h0FF;
      default: return 10'h000;
    endcase
  endfunction

  initial begin
    adc_code = 10'h155;
    adc_done = 1'b0;
    held = 10'h000;
    wait_n = 0;
  end

  // Between answers the result bus toggles, so a stale code is never mistaken for a fresh one.
  always @(posedge mclk) begin
    adc_done <= 1'b0;
    adc_code <= ~adc_code;
    if (adc_start) begin
      held   <= pilot_pos ? code_of(load) : 10'h000;
      wait_n <= slow ? 20 : 2;
    end else if (wait_n > 1) begin
      wait_n <= wait_n - 1;
    end else if (wait_n == 1) begin
      adc_done <= 1'b1;
      adc_code <= held;
      wait_n   <= 0;
    end
  end
endmodule
`default_nettype wire

// ===== testbench/test_ev_pilot_controller.sv
`timescale 1ns/1ps
`default_nettype none
module test_ev_pilot_controller;
  import evpc_pkg::*;
  localparam int PER = 1000;
  logic             mclk = 1'b0;
  logic             rstn = 1'b0;
  logic             selftest_pass = 1'b1;
  logic             fault_in = 1'b0;
  logic             fault_clr = 1'b0;
  logic             derate_en = 1'b0;
  logic [AMP_W-1:0] derate_amps = 7'h00;
  logic             slow = 1'b0;
  evpc_lvl_e        load = LV_12;
  logic [ADC_W-1:0] adc_code;
  logic             adc_done;
  logic             adc_start;
  logic             pilot_pos;
  logic             pilot_neg;
  logic             relay_on;
  logic             evt_pulse;
  evpc_status_s     status;
  int               fails = 0;
  int               cmp_count = 0;
  int               evts;
  int               hi;
  int               lo;
  int               starts;

  always #2.5 mclk = ~mclk;

  evpc_pilot_ctrl #(.PERIOD_CYC(PER), .RATED(80)) u_dut (
    .mclk(mclk), .rstn(rstn), .adc_code(adc_code), .adc_done(adc_done),
    .selftest_pass(selftest_pass), .fault_in(fault_in), .fault_clr(fault_clr),
    .derate_en(derate_en), .derate_amps(derate_amps), .adc_start(adc_start),
    .pilot_pos(pilot_pos), .pilot_neg(pilot_neg), .relay_on(relay_on),
    .evt_pulse(evt_pulse), .status(status));

  evpc_vehicle u_car (
    .mclk(mclk), .adc_start(adc_start), .pilot_pos(pilot_pos), .load(load),
    .slow(slow), .adc_code(adc_code), .adc_done(adc_done));

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk_bit(input string what, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic chk_cnt(input string what, input int exp, input int got);
    cmp_count++;
    if (got != exp) begin
      fails++;
      $display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic chk_st(input evpc_state_e exp);
    cmp_count++;
    if (status.state !== exp) begin
      fails++;
      $display("CHECK FAILED state expected %h seen %h", exp, status.state);
    end
  endtask

  // Waits for a state and counts the event pulses met on the way.
  task automatic go(input evpc_state_e s, input int lim);
    evts = 0;
    for (int i = 0; i < lim && status.state !== s; i++) begin
      @(negedge mclk);
      if (evt_pulse === 1'b1) evts++;
    end
    chk_st(s);
    repeat (3) @(negedge mclk);
  endtask

  task automatic wave();
    hi = 0;
    lo = 0;
    for (int i = 0; i < 3*PER && pilot_pos !== 1'b0; i++) @(negedge mclk);
    for (int i = 0; i < 3*PER && pilot_pos !== 1'b1; i++) @(negedge mclk);
    for (int i = 0; i < 3*PER && pilot_pos === 1'b1; i++) begin
      hi++;
      @(negedge mclk);
    end
    for (int i = 0; i < 3*PER && pilot_neg === 1'b1 && pilot_pos === 1'b0; i++) begin
      lo++;
      @(negedge mclk);
    end
  endtask

  task automatic steady(input logic p, input logic n);
    int bad;
    bad = 0;
    starts = 0;
    for (int i = 0; i < 2*PER; i++) begin
      @(negedge mclk);
      if (pilot_pos !== p || pilot_neg !== n) bad++;
      if (adc_start === 1'b1) starts++;
    end
    chk_cnt("steady pilot", 0, bad);
  endtask

  function automatic int exp_high(input int a);
    return PER * ((a <= 51) ? a * 50 / 3 : a * 4 + 640) / 1000;
  endfunction

  task automatic t_boot();
    chk_st(ST_SELFTEST);
    go(ST_IDLE, 2*SELFTEST_CYC);
    chk_cnt("boot events", 1, evts);
    steady(1'b1, 1'b0);
    chk_cnt("idle samples", 2, starts);
    $display("boot test done");
  endtask

  task automatic t_ready();
    load = LV_9;
    go(ST_READY, 8*PER);
    chk_cnt("ready events", 1, evts);
    chk_bit("level 9", 1'b1, status.level === LV_9);
    chk_bit("relay ready", 1'b0, relay_on);
    wave();
    chk_cnt("high 80A", exp_high(80), hi);
    chk_cnt("period", PER, hi + lo);
    $display("ready test done");
  endtask

  task automatic t_derate();
    int amps[5] = '{65, 51, 30, 6, 80};
    derate_en = 1'b1;
    foreach (amps[i]) begin
      derate_amps = 7'(amps[i]);
      wave();
      wave();
      chk_cnt("derated high", exp_high(amps[i]), hi);
    end
    derate_en = 1'b0;
    $display("derate test done");
  endtask

  task automatic t_charge();
    load = LV_6;
    go(ST_CHARGE, 8*PER);
    chk_bit("relay charge", 1'b1, relay_on);
    chk_bit("status relay", 1'b1, status.relay);
    slow = 1'b1;
    load = LV_3;
    go(ST_VENT, 8*PER);
    chk_bit("relay vent", 1'b1, relay_on);
    chk_bit("level 3", 1'b1, status.level === LV_3);
    wave();
    chk_cnt("vent period", PER, hi + lo);
    slow = 1'b0;
    load = LV_12;
    go(ST_IDLE, 8*PER);
    chk_bit("relay idle", 1'b0, relay_on);
    steady(1'b1, 1'b0);
    $display("charge test done");
  endtask

  task automatic t_err();
    load = LV_9;
    go(ST_READY, 8*PER);
    load = LV_0;
    go(ST_ERR_E, 8*PER);
    chk_bit("relay E", 1'b0, relay_on);
    chk_bit("error E", 1'b1, status.error);
    steady(1'b0, 1'b0);
    chk_cnt("samples E", 0, starts);
    load = LV_12;
    fault_clr = 1'b1;
    @(negedge mclk);
    fault_clr = 1'b0;
    go(ST_IDLE, 2*SELFTEST_CYC + 10);
    fault_in = 1'b1;
    go(ST_ERR_F, 20);
    chk_bit("relay F", 1'b0, relay_on);
    steady(1'b0, 1'b1);
    chk_cnt("samples F", 0, starts);
    fault_in = 1'b0;
    selftest_pass = 1'b0;
    fault_clr = 1'b1;
    @(negedge mclk);
    fault_clr = 1'b0;
    go(ST_SELFTEST, 5);
    go(ST_ERR_F, 2*SELFTEST_CYC + 10);
    selftest_pass = 1'b1;
    fault_clr = 1'b1;
    @(negedge mclk);
    fault_clr = 1'b0;
    go(ST_IDLE, 2*SELFTEST_CYC + 10);
    $display("error test done");
  endtask

  initial begin
    repeat (95000) @(posedge mclk);
    fails++;
    report_and_stop();
  end

  initial begin
    repeat (12) @(negedge mclk);
    rstn = 1'b1;
    t_boot();
    t_ready();
    t_derate();
    t_charge();
    t_err();
    report_and_stop();
  end
endmodule
`default_nettype wire
